//--- orp_cache_model.sv
// Behavioural cache bank facing the outbound response path
`timescale 1ns/1ps
module orp_cache_model (
    input wire logic    sys_clk,
    input wire logic    cache_request_valid,
    output logic        cache_response_valid,
    output logic [31:0] cache_response_bus,
    output logic [1:0]  cache_response_parity,
    output logic        cache_uncorrectable_flag,
    output logic        cache_issue_queue_dequeue,
    output logic        cache_write_buffer_dequeue
);
    logic [31:0] w [16];
    int          bad = 99, uew = 99, lag = 0;

    // ==================================================
    // Header pulse, then data or dummy words back to back
    task automatic respond(input logic [31:0] hdr, input int n);
        @(posedge sys_clk);
        cache_response_valid <= 1'b1;
        cache_response_bus <= hdr;
        for (int i = 0; i < n; i++)
        begin
            @(posedge sys_clk);
            cache_response_valid <= 1'b0;
            cache_response_bus <= w[i];
            cache_response_parity <= {^w[i][31:16], ^w[i][15:0] ^ (i == bad)};
            cache_uncorrectable_flag <= (i == uew);
        end
        @(posedge sys_clk);
        cache_response_valid <= 1'b0;
        // Released bus and parity show the inverse, never a stale value; the flag clears to 0
        cache_response_bus <= ~cache_response_bus;
        cache_response_parity <= ~cache_response_parity;
        cache_uncorrectable_flag <= 1'b0;
    endtask

    // One dispatch pulse per request, then one buffer drain
    initial
    begin
        {cache_response_valid, cache_uncorrectable_flag} = 2'h0;
        {cache_response_bus, cache_response_parity} = 34'h0;
        {cache_issue_queue_dequeue, cache_write_buffer_dequeue} = 2'h0;
        forever
        begin
            do @(posedge sys_clk); while (cache_request_valid !== 1'b1);
            repeat (18 + lag) @(posedge sys_clk);
            cache_issue_queue_dequeue <= 1'b1;
            @(posedge sys_clk);
            cache_issue_queue_dequeue <= 1'b0;
            repeat (lag) @(posedge sys_clk);
            cache_write_buffer_dequeue <= 1'b1;
            @(posedge sys_clk);
            cache_write_buffer_dequeue <= 1'b0;
        end
    end
endmodule

//--- orp_monitor.sv
// Checker of the outbound response path port timing
`timescale 1ns/1ps
module orp_monitor (
    input wire logic         sys_clk,
    input wire logic         resetn,
    input wire logic         cache_response_valid,
    input wire logic [31:0]  cache_response_bus,
    input wire logic [3:0]   iq_credits,
    input wire logic         olc_ilc_dequeue,
    input wire logic         arb_req,
    input wire logic         arb_gnt,
    input wire logic [31:0]  fl_word,
    input wire logic         fl_word_take,
    input wire logic         fl_busy,
    input wire logic [31:0]  cache_request_bus,
    input wire logic         net_header_valid,
    input wire logic         net_payload_present,
    input wire logic [127:0] net_data,
    input wire logic [3:0]   net_parity,
    input wire logic         net_status_valid
);
    // =========================================
    // One clock domain, so one default clocking
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    AST_RESET: assert property ($rose(resetn) |->
        iq_credits == orp_pkg::IQ_CREDITS_MAX && !net_header_valid)
        else $error("credits not full after reset");
    AST_HDR_ONE: assert property (
        net_header_valid |=> !net_header_valid)
        else $error("header valid longer than one cycle");
    // Forwarding asked for once 12 of 16 words are in
    AST_READ_ARB: assert property (cache_response_valid &&
        cache_response_bus[1:0] == orp_pkg::TYPE_READ |->
        ##13 !arb_req ##1 arb_req) else $error("read request timing");
    AST_GNT_CREDIT: assert property (
        arb_req && arb_gnt |=> olc_ilc_dequeue ##1 !olc_ilc_dequeue)
        else $error("credit pulse not after grant");
    AST_BYTE_DROP: assert property (cache_response_valid &&
        cache_response_bus[1:0] == orp_pkg::TYPE_BYTE_WR |->
        ##1 (!arb_req && !olc_ilc_dequeue) [*8])
        else $error("byte write ack was queued");
    AST_STATUS: assert property (
        net_header_valid && net_payload_present |-> ##[4:16] net_status_valid)
        else $error("payload status missing");
    AST_PARITY: assert property (net_status_valid |->
        net_parity == {^net_data[127:96], ^net_data[95:64],
        ^net_data[63:32], ^net_data[31:0]}) else $error("beat parity");
    AST_FL_LEN: assert property ($rose(fl_busy) |->
        fl_word_take ##17 fl_busy ##1 !fl_busy)
        else $error("full line request length");
    AST_FL_DATA: assert property (
        fl_word_take |=> cache_request_bus == $past(fl_word))
        else $error("request word not forwarded");
endmodule

bind orp_outbound orp_monitor u_orp_monitor (
    .sys_clk(sys_clk), .resetn(resetn), .iq_credits(iq_credits),
    .cache_response_valid(cache_response_valid),
    .cache_response_bus(cache_response_bus), .arb_req(arb_req),
    .olc_ilc_dequeue(olc_ilc_dequeue), .arb_gnt(arb_gnt),
    .fl_word(fl_word), .fl_word_take(fl_word_take), .fl_busy(fl_busy),
    .cache_request_bus(cache_request_bus), .net_data(net_data),
    .net_header_valid(net_header_valid), .net_parity(net_parity),
    .net_payload_present(net_payload_present),
    .net_status_valid(net_status_valid)
);

//--- orp_outbound.sv
// Outbound response path from cache bank to network unit
`timescale 1ns/1ps

// Behaviour
// - Read completion: valid pulse with header, then 16 data words.
// - Two parity bits per read data word, checked per word here.
// - Uncorrectable flag per word is recorded and carried with the response.
// - Freeing a response buffer entry pulses a one-cycle credit dequeue.
// - Forwarding starts after three quarters of payload; errors reported later.
// - Request the arbiter, wait grant; credit pulse follows grant a cycle later.
// - Any completion or credit latency is tolerated; no timeouts.
// - Byte-masked write acknowledgements are dropped, never queued.
// - Write-buffer dequeue pulse returns one of four write buffer credits.
// - Full-line write completion: header then eight dummy cycles discarded.
// - A full-line write request occupies 18 consecutive request cycles.
// - Network side has no backpressure; packets may go back to back.
// - Nonposted full-line write completion produces an acknowledge packet.
// - Acknowledges may return in any order.
// - Each packet opens with a one-cycle header-valid and 128-bit header.
// - Payload flag set for four payload beats, clear for acknowledges.
// - Payload big endian, critical word first, wrapping at the line end.
// - Four parity bits per beat, bit N is XOR of word N.
module orp_outbound #(
    parameter int FIFO_W = orp_pkg::INT_W + 5
) (
    input  wire logic         sys_clk,
    input  wire logic         resetn,
    input  wire logic         cache_response_valid,
    input  wire logic [31:0]  cache_response_bus,
    input  wire logic [1:0]   cache_response_parity,
    input  wire logic         cache_uncorrectable_flag,
    input  wire logic         cache_issue_queue_dequeue,
    input  wire logic         cache_write_buffer_dequeue,
    input  wire logic         iq_credit_take,
    input  wire logic         wib_credit_take,
    output logic      [3:0]   iq_credits,
    output logic      [3:0]   wib_credits,
    output logic              olc_ilc_dequeue,
    output logic              arb_req,
    input  wire logic         arb_gnt,
    input  wire logic         fl_start,
    input  wire logic [31:0]  fl_word,
    output logic              fl_word_take,
    output logic              fl_busy,
    output logic              cache_request_valid,
    output logic      [31:0]  cache_request_bus,
    output logic              net_header_valid,
    output logic              net_payload_present,
    output logic      [127:0] net_data,
    output logic      [3:0]   net_parity,
    output logic              net_status_valid,
    output logic              net_parity_error,
    output logic              net_ue_error
);

    // ========================================================
    // Helpers
    // Even parity per 16-bit half of a cache word
    function automatic logic [1:0] word_par(input logic [31:0] w);
        word_par = {^w[31:16], ^w[15:0]};
    endfunction
    function automatic logic [3:0] beat_par(input logic [127:0] b);
        logic [3:0] p;
        p = 4'h0;
        for (int n = 0; n < 4; n++)
            p[n] = ^b[32*n +: 32];
        beat_par = p;
    endfunction
    // ========================================================
    // Declarations
    orp_pkg::orp_cap_t  cap_state_r;
    orp_pkg::orp_fwd_t  fwd_state_r;
    logic [31:0]        line_mem [orp_pkg::RD_WORDS];
    logic [31:0]        hdr_r;
    logic [4:0]         cap_cnt_r, words_have, pair_need, fl_cnt_r;
    logic               perr_r, ue_r, is_read_r, posted_free_r, gnt_d_r;
    logic [2:0]         pair_r;
    logic               fwd_done, in_push, in_ready, out_valid;
    logic [1:0]         in_type;
    logic [FIFO_W-1:0]  in_entry, out_entry;
    logic [FIFO_W-1:0]  fifo_mem [2];
    logic               wr_ptr_r, rd_ptr_r, half_r, fl_active_r;
    logic [1:0]         fifo_cnt_r;
    logic [63:0]        hi_half_r;
    logic [127:0]       beat;
    assign in_type = cache_response_bus[orp_pkg::HDR_TYPE_LSB +: 2];

    // ========================================================
    // Capture of cache responses
    // One line buffer; a new response waits until the entry is freed
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cap_state_r   <= orp_pkg::CAP_IDLE;
            cap_cnt_r     <= 5'h0;
            hdr_r         <= 32'h0;
            perr_r        <= 1'b0;
            ue_r          <= 1'b0;
            is_read_r     <= 1'b0;
            posted_free_r <= 1'b0;
        end
        else
        begin
            posted_free_r <= 1'b0;
            case (cap_state_r)
                orp_pkg::CAP_IDLE:
                begin
                    cap_cnt_r <= 5'h0;
                    if (cache_response_valid)
                    begin
                        hdr_r     <= cache_response_bus;
                        perr_r    <= 1'b0;
                        ue_r      <= 1'b0;
                        is_read_r <= (in_type == orp_pkg::TYPE_READ);
                        if (in_type == orp_pkg::TYPE_READ)
                            cap_state_r <= orp_pkg::CAP_READ;
                        else if (in_type == orp_pkg::TYPE_LINE_WR)
                            cap_state_r <= orp_pkg::CAP_DUMMY;
                        // Byte-masked and unknown acks leave no trace
                    end
                end
                orp_pkg::CAP_READ:
                begin
                    line_mem[cap_cnt_r[3:0]] <= cache_response_bus;
                    if (word_par(cache_response_bus) != cache_response_parity)
                        perr_r <= 1'b1;
                    if (cache_uncorrectable_flag)
                        ue_r <= 1'b1;
                    cap_cnt_r <= cap_cnt_r + 5'h1;
                    if (cap_cnt_r == orp_pkg::LAST_RD_WORD)
                        cap_state_r <= orp_pkg::CAP_HOLD;
                end
                // Dummy words are counted and discarded
                orp_pkg::CAP_DUMMY:
                begin
                    cap_cnt_r <= cap_cnt_r + 5'h1;
                    if (cap_cnt_r == orp_pkg::LAST_DUMMY)
                    begin
                        if (hdr_r[orp_pkg::HDR_NP_BIT])
                            cap_state_r <= orp_pkg::CAP_HOLD;
                        else
                        begin
                            posted_free_r <= 1'b1;
                            cap_state_r   <= orp_pkg::CAP_IDLE;
                        end
                    end
                end
                orp_pkg::CAP_HOLD:
                    if (fwd_done)
                        cap_state_r <= orp_pkg::CAP_IDLE;
                default:
                    cap_state_r <= orp_pkg::CAP_IDLE;
            endcase
        end
    end

    // ========================================================
    // Forwarding onto the internal 64-bit datapath
    // Each pair waits for its words, so the last error summary is final
    assign words_have = (cap_state_r == orp_pkg::CAP_HOLD) ?
                        orp_pkg::ALL_WORDS : cap_cnt_r;
    assign pair_need  = {1'b0, pair_r, 1'b0} + 5'h2;
    assign arb_req    = (fwd_state_r == orp_pkg::FWD_REQ);
    always_comb
    begin
        in_push  = 1'b0;
        in_entry = '0;
        fwd_done = 1'b0;
        if (fwd_state_r == orp_pkg::FWD_HDR)
        begin
            in_push  = 1'b1;
            // Flags: sop, pay, eop, perr, ue
            in_entry = {1'b1, is_read_r, ~is_read_r, 2'b00,
                        32'h0, hdr_r};
            fwd_done = in_ready & ~is_read_r;
        end
        else if (fwd_state_r == orp_pkg::FWD_DATA &&
                 words_have >= pair_need)
        begin
            in_push  = 1'b1;
            // Earlier word in the upper half: big endian order
            in_entry = {1'b0, 1'b1, pair_r == orp_pkg::LAST_PAIR,
                        perr_r, ue_r,
                        line_mem[{pair_r, 1'b0}],
                        line_mem[{pair_r, 1'b1}]};
            fwd_done = in_ready & (pair_r == orp_pkg::LAST_PAIR);
        end
    end
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            fwd_state_r <= orp_pkg::FWD_IDLE;
            pair_r      <= 3'h0;
        end
        else
        begin
            case (fwd_state_r)
                orp_pkg::FWD_IDLE:
                begin
                    pair_r <= 3'h0;
                    if ((cap_state_r == orp_pkg::CAP_READ &&
                         cap_cnt_r >= orp_pkg::FWD_START_WORDS) ||
                        cap_state_r == orp_pkg::CAP_HOLD)
                        fwd_state_r <= orp_pkg::FWD_REQ;
                end
                // Waits on the grant as long as it takes
                orp_pkg::FWD_REQ:
                    if (arb_gnt)
                        fwd_state_r <= orp_pkg::FWD_HDR;
                orp_pkg::FWD_HDR:
                    if (in_ready)
                        fwd_state_r <= is_read_r ? orp_pkg::FWD_DATA
                                                 : orp_pkg::FWD_IDLE;
                orp_pkg::FWD_DATA:
                    if (in_push && in_ready)
                    begin
                        pair_r <= pair_r + 3'h1;
                        if (pair_r == orp_pkg::LAST_PAIR)
                            fwd_state_r <= orp_pkg::FWD_IDLE;
                    end
                default:
                    fwd_state_r <= orp_pkg::FWD_IDLE;
            endcase
        end
    end
    // Credit back one cycle after the grant, or for a freed posted ack
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            gnt_d_r <= 1'b0;
        else
            gnt_d_r <= arb_gnt & (fwd_state_r == orp_pkg::FWD_REQ);
    end
    assign olc_ilc_dequeue = gnt_d_r | posted_free_r;

    // ========================================================
    // Two-entry buffer on the internal datapath
    assign in_ready  = (fifo_cnt_r != 2'h2);
    assign out_valid = (fifo_cnt_r != 2'h0);
    assign out_entry = fifo_mem[rd_ptr_r];
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_ptr_r   <= 1'b0;
            rd_ptr_r   <= 1'b0;
            fifo_cnt_r <= 2'h0;
        end
        else
        begin
            if (in_push && in_ready)
            begin
                fifo_mem[wr_ptr_r] <= in_entry;
                wr_ptr_r           <= ~wr_ptr_r;
            end
            // Network side never stalls, so the drain takes every word
            if (out_valid)
                rd_ptr_r <= ~rd_ptr_r;
            fifo_cnt_r <= fifo_cnt_r + {1'b0, in_push & in_ready}
                                     - {1'b0, out_valid};
        end
    end

    // ========================================================
    // Packet builder toward the network unit
    // ========================================================
    assign beat = {hi_half_r, out_entry[63:0]};

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            net_header_valid    <= 1'b0;
            net_payload_present <= 1'b0;
            net_data            <= 128'h0;
            net_parity          <= 4'h0;
            net_status_valid    <= 1'b0;
            net_parity_error    <= 1'b0;
            net_ue_error        <= 1'b0;
            hi_half_r           <= 64'h0;
            half_r              <= 1'b0;
        end
        else
        begin
            net_header_valid <= 1'b0;
            net_status_valid <= 1'b0;
            if (out_valid && out_entry[FIFO_W-1])
            begin
                // Header beat; back to back is allowed
                net_header_valid    <= 1'b1;
                net_payload_present <= out_entry[FIFO_W-2];
                net_data            <= {64'h0, out_entry[63:0]};
                net_parity          <= 4'h0;
                half_r              <= 1'b0;
            end
            else if (out_valid && !half_r)
            begin
                hi_half_r <= out_entry[63:0];
                half_r    <= 1'b1;
            end
            else if (out_valid)
            begin
                net_data         <= beat;
                net_parity       <= beat_par(beat);
                half_r           <= 1'b0;
                net_status_valid <= out_entry[FIFO_W-3];
                net_parity_error <= out_entry[FIFO_W-4];
                net_ue_error     <= out_entry[FIFO_W-5];
            end
        end
    end

    // ========================================================
    // Credit counters for the inbound side
    // ========================================================
    // Return and take in one cycle cancel, so no pulse is lost
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            iq_credits  <= orp_pkg::IQ_CREDITS_MAX;
            wib_credits <= orp_pkg::WIB_CREDITS_MAX;
        end
        else
        begin
            iq_credits  <= iq_credits + {3'h0, cache_issue_queue_dequeue}
                                      - {3'h0, iq_credit_take};
            wib_credits <= wib_credits + {3'h0, cache_write_buffer_dequeue}
                                       - {3'h0, wib_credit_take};
        end
    end

    // ========================================================
    // Full-line write request sequencer
    assign fl_word_take = fl_active_r;
    assign fl_busy      = fl_active_r;
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            fl_active_r         <= 1'b0;
            fl_cnt_r            <= 5'h0;
            cache_request_valid <= 1'b0;
            cache_request_bus   <= 32'h0;
        end
        else
        begin
            cache_request_valid <= fl_active_r & (fl_cnt_r == 5'h0);
            cache_request_bus   <= fl_active_r ? fl_word : 32'h0;
            fl_cnt_r            <= fl_active_r ? fl_cnt_r + 5'h1 : 5'h0;
            if (!fl_active_r)
                fl_active_r <= fl_start;
            else if (fl_cnt_r == orp_pkg::FL_REQ_LAST)
                fl_active_r <= 1'b0;
        end
    end

endmodule

//--- orp_pkg.sv
// Constants and types shared by the outbound response path
package orp_pkg;

    // ========================================================
    // Cache response side
    // ========================================================
    localparam int          CACHE_W        = 32;
    localparam int          RD_WORDS       = 16;
    localparam int          WR_DUMMY       = 8;
    localparam logic [4:0]  FWD_START_WORDS = 5'hC;
    localparam logic [4:0]  LAST_RD_WORD   = 5'hF;
    localparam logic [4:0]  LAST_DUMMY     = 5'h7;
    localparam logic [4:0]  ALL_WORDS      = 5'h10;

    // Response header type field
    localparam int          HDR_TYPE_LSB   = 0;
    localparam int          HDR_NP_BIT     = 2;
    localparam logic [1:0]  TYPE_READ      = 2'h0;
    localparam logic [1:0]  TYPE_BYTE_WR   = 2'h1;
    localparam logic [1:0]  TYPE_LINE_WR   = 2'h2;

    // ========================================================
    // Internal datapath and network side
    // ========================================================
    localparam int          INT_W          = 64;
    localparam int          NET_W          = 128;
    localparam logic [2:0]  LAST_PAIR      = 3'h7;

    // ========================================================
    // Credits and full-line request
    // ========================================================
    localparam logic [3:0]  IQ_CREDITS_MAX  = 4'h8;
    localparam logic [3:0]  WIB_CREDITS_MAX = 4'h4;
    localparam logic [4:0]  FL_REQ_LAST    = 5'h11;

    typedef enum {CAP_IDLE, CAP_READ, CAP_DUMMY, CAP_HOLD} orp_cap_t;
    typedef enum {FWD_IDLE, FWD_REQ, FWD_HDR, FWD_DATA} orp_fwd_t;

endpackage

//--- tb_orp_outbound.sv
// Self-checking bench of the outbound response path
`timescale 1ns/1ps
module tb_orp_outbound;
    logic         sys_clk = 1'b0;
    logic         resetn = 1'b0;
    logic         iq_credit_take = 1'b0;
    logic         wib_credit_take = 1'b0;
    logic         arb_gnt = 1'b0;
    logic         fl_start = 1'b0;
    logic [31:0]  fl_word = 32'h0;
    logic         cache_response_valid, cache_uncorrectable_flag;
    logic         cache_issue_queue_dequeue, cache_write_buffer_dequeue;
    logic [31:0]  cache_response_bus, cache_request_bus, hd, wd_r;
    logic [1:0]   cache_response_parity, ee;
    logic [3:0]   iq_credits, wib_credits, net_parity;
    logic         olc_ilc_dequeue, arb_req, fl_word_take, fl_busy;
    logic         cache_request_valid, net_header_valid, net_status_valid;
    logic         net_payload_present, net_parity_error, net_ue_error;
    logic         tk_r = 1'b0, act = 1'b0;
    logic [127:0] net_data, eb [4];
    logic [31:0]  hq[$], wq[$];
    logic [1:0]   eq[$];
    int           seed = 89193, fails = 0, check_count = 0, bi = 0;
    int           deq_n = 0, deq_e = 0, tk_n = 0;
    int           iq_e = orp_pkg::IQ_CREDITS_MAX;
    int           wib_e = orp_pkg::WIB_CREDITS_MAX;
    int           lags[4] = '{0, 1, 7, 20};

    always #12.5 sys_clk = ~sys_clk;

    orp_outbound dut (
        .sys_clk, .resetn, .cache_response_valid, .cache_response_bus,
        .cache_response_parity, .cache_uncorrectable_flag,
        .cache_issue_queue_dequeue, .cache_write_buffer_dequeue,
        .iq_credit_take, .wib_credit_take, .iq_credits, .wib_credits,
        .olc_ilc_dequeue, .arb_req, .arb_gnt, .fl_start, .fl_word,
        .fl_word_take, .fl_busy, .cache_request_valid, .cache_request_bus,
        .net_header_valid, .net_payload_present, .net_data, .net_parity,
        .net_status_valid, .net_parity_error, .net_ue_error
    );
    orp_cache_model cm (
        .sys_clk, .cache_request_valid, .cache_response_valid,
        .cache_response_bus, .cache_response_parity,
        .cache_uncorrectable_flag, .cache_issue_queue_dequeue,
        .cache_write_buffer_dequeue
    );

    // ==============================
    // Comparison, verdict, watchdog
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        if (fails == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        #400000;
        fails++;
        conclude();
    end

    // ==================================================
    // One response, queued in the reference before sending
    task automatic send(input logic [1:0] ty, input logic np,
                        input int bad, input int uew);
        int k0;
        hd = $random(seed);
        hd[2:0] = {np, ty};
        for (int i = 0; i < 16; i++)
            cm.w[i] = $random(seed);
        cm.bad = (ty == orp_pkg::TYPE_READ) ? bad : 99;
        cm.uew = (ty == orp_pkg::TYPE_READ) ? uew : 99;
        if (ty == orp_pkg::TYPE_READ || (ty == orp_pkg::TYPE_LINE_WR && np))
            hq.push_back(hd);
        if (ty == orp_pkg::TYPE_READ)
        begin
            for (int i = 0; i < 16; i++)
                wq.push_back(cm.w[i]);
            eq.push_back({bad < 16, uew < 16});
        end
        deq_e += (ty != orp_pkg::TYPE_BYTE_WR);
        k0 = deq_n;
        cm.respond(hd, ty == orp_pkg::TYPE_READ ? 16 : ty[1] ? 8 : 0);
        // The next response waits for the freed entry
        for (int j = 0; j < 300 && deq_n == k0 && ty != 2'h1; j++)
            @(posedge sys_clk);
        // Credit comes a cycle after the grant; the line drains a few cycles later
        repeat (10) @(posedge sys_clk);
    endtask

    // Full-line request, taking one credit of each kind
    task automatic fl_req(input int lag);
        cm.lag = lag;
        @(posedge sys_clk);
        {fl_start, iq_credit_take, wib_credit_take} <= 3'h7;
        @(posedge sys_clk);
        {fl_start, iq_credit_take, wib_credit_take} <= 3'h0;
        repeat (60 + 2 * lag) @(posedge sys_clk);
    endtask

    // Random request words and grant stalls
    always @(posedge sys_clk)
    begin
        fl_word <= $random(seed);
        arb_gnt <= arb_req && ($random(seed) % 3 != 0);
    end

    // Reference credit counts and request-bus words
    always @(posedge sys_clk)
    begin
        deq_n += (olc_ilc_dequeue === 1'b1);
        if (resetn)
        begin
            chk(iq_credits, iq_e);
            chk(wib_credits, wib_e);
            iq_e += cache_issue_queue_dequeue - iq_credit_take;
            wib_e += cache_write_buffer_dequeue - wib_credit_take;
            if (tk_r)
                chk({cache_request_valid, cache_request_bus}, {tk_n == 1, wd_r});
            if (tk_r && !fl_word_take)
                chk(tk_n, 18);
            tk_n = fl_word_take ? tk_n + 1 : 0;
            tk_r = fl_word_take;
            wd_r = fl_word;
        end
    end

    // Network packets against the reference queues
    always @(posedge sys_clk)
    begin
        if (resetn && net_header_valid === 1'b1)
        begin
            hd = hq.size() ? hq.pop_front() : 32'hFFFFFFFF;
            act = (hd[1:0] == orp_pkg::TYPE_READ);
            chk({net_payload_present, net_data}, {act, 96'h0, hd});
            bi = 0;
            for (int k = 0; k < 16 && act; k++)
                eb[k / 4][127 - 32 * (k % 4) -: 32] = wq.pop_front();
            ee = act ? eq.pop_front() : 2'h0;
        end
        else if (act)
        begin
            if (bi < 4 && net_data === eb[bi])
            begin
                chk(net_parity, {^eb[bi][127:96], ^eb[bi][95:64],
                                 ^eb[bi][63:32], ^eb[bi][31:0]});
                bi++;
            end
            if (net_status_valid === 1'b1)
            begin
                chk({bi, net_parity_error, net_ue_error}, {32'h4, ee});
                act = 1'b0;
            end
        end
    end

    // Main sequence
    initial
    begin
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk({iq_credits, wib_credits, net_header_valid}, 9'h108);
        send(orp_pkg::TYPE_READ, 1'b0, 99, 99);
        send(orp_pkg::TYPE_READ, 1'b0, 0, 15);
        send(orp_pkg::TYPE_BYTE_WR, 1'b0, 99, 99);
        send(orp_pkg::TYPE_LINE_WR, 1'b1, 99, 99);
        send(orp_pkg::TYPE_LINE_WR, 1'b0, 99, 99);
        fork
            repeat (30) send(2'($unsigned($random(seed)) % 3),
                1'($random(seed)), $unsigned($random(seed)) % 32,
                $unsigned($random(seed)) % 32);
            foreach (lags[i]) fl_req(lags[i]);
        join
        repeat (40) @(posedge sys_clk);
        chk(deq_n, deq_e);
        chk(hq.size(), 0);
        conclude();
    end
endmodule
